// >>> src/timer8_compare_unit.sv
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
// What this block does
// - in non-pwm modes action bits choose what a compare match does to the internal output state.
// - nonzero action bits replace the port output value with the output state.
// - pin direction stays with the direction bit; software sets it to output.
// - override selection uses only the action bits, never the waveform mode.
// - output state can be forced while the pin is still disabled.
// - action zero leaves the output state unchanged on a match, any mode.
// - newly written action bits first apply at the next match after the write.
// - in non-pwm modes the force strobe applies the action bits written with it at once.
// - only mode bits shape the count sequence; action bits never do.
// - mode zero only increments, never cleared by match, wraps ff to 00.
// - normal mode sets overflow flag in the cycle the counter becomes zero.
// - counting only sets overflow flag; interrupt service clears it.
// - normal mode accepts a counter write at any moment.
// - mode two clears the counter on the tick after it equals match value.
// - clear-on-match mode sets the match flag every period at top.
// - match writes are unbuffered; lower value than count wraps via ff first.
// - clear-on-match with action one toggles the state each match.
// - toggle rate is tick rate over one plus match value; the output period is twice that.
// - clear-on-match sets overflow flag only when stepping ff to 00.
// - equality sets the match flag on the following timer tick.
// - forced compare changes only the output state, not flag or counter.
// - writing one to the match flag clears it; zero leaves it.
module timer8_compare_unit
  import timer8_pkg::*;
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 clk_en_i,
  input  wire logic                 timer_tick_i,
  input  wire logic                 ovf_serviced_i,
  input  wire logic                 match_serviced_i,
  input  wire timer8_pkg::axi_req_t axi_req_i,
  output timer8_pkg::axi_rsp_t      axi_rsp_o,
  output timer8_pkg::pin_t          pin_o,
  output logic [7:0]                counter_value_o,
  output logic                      overflow_flag_o,
  output logic                      match_flag_o
);
  import timer8_pkg::*;

  // next output state for a given action; action zero holds the state
  function automatic logic apply_action(input out_action_t act, input logic cur);
    logic res;
    res = cur;
    unique case (act)
      ACT_NONE:   res = cur;
      ACT_TOGGLE: res = ~cur;
      ACT_CLEAR:  res = 1'b0;
      ACT_SET:    res = 1'b1;
    endcase
    return res;
  endfunction

  logic       aw_got_q;
  logic [7:0] aw_addr_q;
  logic       w_got_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic       aw_ready_q;
  logic       w_ready_q;
  logic       b_valid_q;
  logic [1:0] b_resp_q;
  logic       ar_ready_q;
  logic       r_valid_q;
  logic [31:0] r_data_q;
  logic [1:0] r_resp_q;

  wave_mode_t  mode_q;
  out_action_t action_q;
  logic        dir_q;
  logic        port_q;
  logic [7:0]  count_q;
  logic [7:0]  match_q;
  logic        ovf_q;
  logic        mflag_q;
  logic        state_q;
  logic        block_q;
  pin_t        pin_q;

  logic        wr_fire;
  logic        wr_ctrl;
  logic        wr_count;
  logic        wr_match;
  logic        wr_flags;
  logic        tick;
  logic        is_pwm;
  logic        hit;
  logic        force_now;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic [7:0]  wr_byte;
  logic        ovf_set;
  logic        ovf_clr;
  logic        mflag_clr;

  // a write is done once address and data are both held and no response waits
  always_comb begin
    wr_fire  = clk_en_i && aw_got_q && w_got_q && !b_valid_q;
    wr_ctrl  = wr_fire && (aw_addr_q == CTRL_OFS);
    wr_count = wr_fire && (aw_addr_q == COUNT_OFS) && w_strb_q[0];
    wr_match = wr_fire && (aw_addr_q == MATCH_OFS) && w_strb_q[0];
    wr_flags = wr_fire && (aw_addr_q == FLAGS_OFS) && w_strb_q[0];
    tick     = clk_en_i && timer_tick_i;
    is_pwm   = (mode_q == MODE_PHASE_PWM) || (mode_q == MODE_FAST_PWM);
    // a match is blocked in the tick after a counter write
    hit       = tick && !wr_count && !block_q && (count_q == match_q);
    force_now = wr_ctrl && w_strb_q[0] && w_data_q[FORCE_BIT] && !is_pwm;
    // flag set and clear terms, shared by the flag logic and its checks
    wr_byte   = w_data_q[7:0];
    ovf_set   = tick && !wr_count && (count_q == COUNT_MAX) && !is_pwm;
    ovf_clr   = clk_en_i && (ovf_serviced_i || (wr_flags && w_data_q[OVF_BIT]));
    mflag_clr = clk_en_i && (match_serviced_i || (wr_flags && w_data_q[MATCH_BIT]));
  end

  // write address and data channels, taken in either order
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_got_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_got_q       <= 1'b0;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      aw_ready_q    <= 1'b1;
      w_ready_q     <= 1'b1;
      b_valid_q     <= 1'b0;
      b_resp_q      <= RESP_OKAY;
    end else if (clk_en_i) begin
      if (axi_req_i.awvalid && aw_ready_q) begin
        aw_got_q   <= 1'b1;
        aw_addr_q  <= axi_req_i.awaddr;
        aw_ready_q <= 1'b0;
      end
      if (axi_req_i.wvalid && w_ready_q) begin
        w_got_q   <= 1'b1;
        w_data_q  <= axi_req_i.wdata;
        w_strb_q  <= axi_req_i.wstrb;
        w_ready_q <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_q  <= 1'b0;
        w_got_q   <= 1'b0;
        b_valid_q <= 1'b1;
        b_resp_q  <= (aw_addr_q[1:0] == 2'h0 && aw_addr_q <= FLAGS_OFS)
                     ? RESP_OKAY : RESP_SLVERR;
      end
      // ready comes back only after the response is taken: one write in flight
      if (b_valid_q && axi_req_i.bready) begin
        b_valid_q  <= 1'b0;
        aw_ready_q <= 1'b1;
        w_ready_q  <= 1'b1;
      end
    end
  end

  // read decode
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    unique case (axi_req_i.araddr)
      CTRL_OFS: begin
        rd_data[MODE_LSB +: 2]   = mode_q;
        rd_data[ACTION_LSB +: 2] = action_q;
        rd_data[DIR_BIT]         = dir_q;
        rd_data[PORT_BIT]        = port_q;
      end
      COUNT_OFS: rd_data[7:0] = count_q;
      MATCH_OFS: rd_data[7:0] = match_q;
      FLAGS_OFS: begin
        rd_data[OVF_BIT]   = ovf_q;
        rd_data[MATCH_BIT] = mflag_q;
        rd_data[STATE_BIT] = state_q;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ar_ready_q <= 1'b1;
      r_valid_q  <= 1'b0;
      r_data_q   <= 32'h0000_0000;
      r_resp_q   <= RESP_OKAY;
    end else if (clk_en_i) begin
      if (axi_req_i.arvalid && ar_ready_q) begin
        ar_ready_q <= 1'b0;
        r_valid_q  <= 1'b1;
        r_data_q   <= rd_data;
        r_resp_q   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (r_valid_q && axi_req_i.rready) begin
        r_valid_q  <= 1'b0;
        ar_ready_q <= 1'b1;
      end
    end
  end

  // control bits; action takes effect immediately, so the next match sees it
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_q   <= MODE_NORMAL;
      action_q <= ACT_NONE;
      dir_q    <= 1'b0;
      port_q   <= 1'b0;
    end else if (wr_ctrl) begin
      if (w_strb_q[0]) begin
        mode_q   <= wave_mode_t'(w_data_q[MODE_LSB +: 2]);
        action_q <= out_action_t'(w_data_q[ACTION_LSB +: 2]);
      end
      if (w_strb_q[1]) begin
        dir_q  <= w_data_q[DIR_BIT];
        port_q <= w_data_q[PORT_BIT];
      end
    end
  end

  // match value is unbuffered in every mode, pwm included, so a value below
  // the count is missed until the counter wraps
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      match_q <= MATCH_RST;
    end else if (wr_match) begin
      match_q <= w_data_q[7:0];
    end
  end

  // counter: a software write has priority over any count or clear
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_q <= COUNT_RST;
      block_q <= 1'b0;
    end else if (clk_en_i) begin
      if (wr_count) begin
        count_q <= w_data_q[7:0];
        block_q <= 1'b1;
      end else if (tick) begin
        block_q <= 1'b0;
        // sequence depends on the mode alone; the action is not consulted
        if (mode_q == MODE_CLEAR_ON_MATCH && hit) begin
          count_q <= COUNT_BOT;
        end else begin
          count_q <= count_q + 8'h01;
        end
      end
    end
  end

  // flags: hardware set wins over a software or service clear
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ovf_q   <= 1'b0;
      mflag_q <= 1'b0;
    end else if (clk_en_i) begin
      if (ovf_set) begin
        ovf_q <= 1'b1;
      end else if (ovf_clr) begin
        ovf_q <= 1'b0;
      end
      if (hit) begin
        mflag_q <= 1'b1;
      end else if (mflag_clr) begin
        mflag_q <= 1'b0;
      end
    end
  end

  // output state: the force strobe acts only here, never on flag or count
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= 1'b0;
    end else if (force_now) begin
      state_q <= apply_action(out_action_t'(w_data_q[ACTION_LSB +: 2]), state_q);
    end else if (hit && !is_pwm) begin
      state_q <= apply_action(action_q, state_q);
    end
  end

  // pin: override depends on action bits only; direction stays with software
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_q <= '0;
    end else if (clk_en_i) begin
      pin_q.out <= (action_q != ACT_NONE) ? state_q : port_q;
      pin_q.oe  <= dir_q;
    end
  end

  assign axi_rsp_o       = {aw_ready_q, w_ready_q, b_valid_q, b_resp_q,
                            ar_ready_q, r_valid_q, r_data_q, r_resp_q};
  assign pin_o           = pin_q;
  assign counter_value_o = count_q;
  assign overflow_flag_o = ovf_q;
  assign match_flag_o    = mflag_q;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_normal_wrap: assert property (
    tick && !wr_count && mode_q == MODE_NORMAL && count_q == COUNT_MAX
    |=> count_q == COUNT_BOT && ovf_q)
    else $error("normal mode did not wrap to zero with overflow");

  chk_normal_no_clear: assert property (
    tick && !wr_count && mode_q == MODE_NORMAL && count_q != COUNT_MAX
    |=> count_q == $past(count_q) + 8'h01)
    else $error("normal mode counter did not increment");

  chk_ctc_clear: assert property (
    hit && mode_q == MODE_CLEAR_ON_MATCH |=> count_q == COUNT_BOT && mflag_q)
    else $error("clear-on-match did not clear counter and set flag");

  chk_match_flag_set: assert property (
    tick && !wr_count && !block_q && count_q == match_q |=> mflag_q)
    else $error("match flag not set on tick after equality");

  chk_ovf_only_max: assert property (
    !ovf_q && !$past(ovf_q) ##1 ovf_q |-> $past(count_q) == COUNT_MAX)
    else $error("overflow flag set away from max");

  chk_action_none_hold: assert property (
    hit && action_q == ACT_NONE && !wr_ctrl |=> state_q == $past(state_q))
    else $error("action zero changed output state");

  chk_toggle_state: assert property (
    hit && !is_pwm && action_q == ACT_TOGGLE && !wr_ctrl |=> state_q != $past(state_q))
    else $error("toggle action did not invert state");

  chk_force_no_flag: assert property (
    force_now && !hit && !mflag_q |=> !mflag_q)
    else $error("force strobe set the match flag");

  chk_pin_override: assert property (
    clk_en_i && action_q != ACT_NONE |=> pin_q.out == $past(state_q))
    else $error("pin not driven from output state");

  chk_pin_direction: assert property (
    clk_en_i |=> pin_q.oe == $past(dir_q))
    else $error("pin enable not following direction bit");

  chk_flag_w1c: assert property (
    wr_flags && w_data_q[MATCH_BIT] && !hit |=> !mflag_q)
    else $error("write one did not clear match flag");

  chk_ovf_hold: assert property (
    ovf_q && !ovf_clr |=> ovf_q)
    else $error("overflow flag cleared without service or write");

  chk_ovf_set_wins: assert property (
    ovf_set |=> ovf_q)
    else $error("overflow set lost against a clear");

  chk_pin_port: assert property (
    clk_en_i && action_q == ACT_NONE |=> pin_q.out == $past(port_q))
    else $error("pin not driven from port value with action zero");

  chk_count_write: assert property (
    wr_count |=> count_q == $past(wr_byte))
    else $error("counter write did not land");

  chk_match_write: assert property (
    wr_match |=> match_q == $past(wr_byte))
    else $error("match value write did not land");

  chk_force_count: assert property (
    force_now && !tick |=> count_q == $past(count_q))
    else $error("force strobe moved the counter");

  chk_pwm_no_force: assert property (
    wr_ctrl && w_data_q[FORCE_BIT] && is_pwm |=> state_q == $past(state_q))
    else $error("force strobe acted in a pwm mode");

  cov_ctc_period: cover property (hit && mode_q == MODE_CLEAR_ON_MATCH);
  cov_normal_ovf: cover property (tick && mode_q == MODE_NORMAL && count_q == COUNT_MAX);
  cov_force: cover property (force_now);
  cov_set_clear_race: cover property (hit && wr_flags && w_data_q[MATCH_BIT]);

endmodule

// >>> src/timer8_pkg.sv
package timer8_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] COUNT_OFS = 8'h04;
  localparam logic [7:0] MATCH_OFS = 8'h08;
  localparam logic [7:0] FLAGS_OFS = 8'h0c;

  // control register fields
  localparam int MODE_LSB   = 0;   // waveform_mode_select, 2 bits
  localparam int ACTION_LSB = 4;   // output_action_select, 2 bits
  localparam int FORCE_BIT  = 7;   // force_match_strobe, write only
  localparam int DIR_BIT    = 8;   // pin_direction_bit
  localparam int PORT_BIT   = 9;   // general port output value

  // flags register fields
  localparam int OVF_BIT   = 0;    // overflow_flag, write one to clear
  localparam int MATCH_BIT = 1;    // match_flag, write one to clear
  localparam int STATE_BIT = 2;    // waveform_out_state, read only

  // reset values and counter extremes
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] MATCH_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOT = 8'h00;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_PHASE_PWM,
    MODE_CLEAR_ON_MATCH,
    MODE_FAST_PWM
  } wave_mode_t;

  typedef enum logic [1:0] {
    ACT_NONE,
    ACT_TOGGLE,
    ACT_CLEAR,
    ACT_SET
  } out_action_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_t;

endpackage

// >>> tb/pin_pad_model.sv
`timescale 1ns/1ps
module pin_pad_model
  import timer8_pkg::*;
(
  input  wire timer8_pkg::pin_t pin_i,
  output logic                  pad_o
);
  // board pin with a pull-up: a released pin reads high, never the last driven value
  assign pad_o = pin_i.oe ? pin_i.out : 1'b1;
endmodule

// >>> tb/tb_timer8_compare_unit.sv
`timescale 1ns/1ps
module tb_timer8_compare_unit;
  import timer8_pkg::*;
  // flags column is {output state, match, overflow}
  typedef struct packed {
    logic [1:0] md;
    logic [1:0] ac;
    logic       pt;
    logic [7:0] mv;
    logic [7:0] cv;
    logic [3:0] n;
    logic [7:0] ec;
    logic [2:0] ef;
    logic       ep;
  } row_t;
  // rows run in order: the output state carries over from one row to the next
  localparam row_t ROWS [8] = '{
    '{2'h0, 2'h0, 1'h1, 8'h05, 8'hfd, 4'h4, 8'h01, 3'h1, 1'h1},
    '{2'h0, 2'h1, 1'h0, 8'h03, 8'h01, 4'h4, 8'h05, 3'h6, 1'h1},
    '{2'h2, 2'h1, 1'h0, 8'h02, 8'h00, 4'h7, 8'h01, 3'h6, 1'h1},
    '{2'h2, 2'h0, 1'h0, 8'h01, 8'h00, 4'h3, 8'h01, 3'h6, 1'h0},
    '{2'h2, 2'h2, 1'h0, 8'h10, 8'hfe, 4'h4, 8'h02, 3'h5, 1'h1},
    '{2'h2, 2'h2, 1'h0, 8'h00, 8'h00, 4'h2, 8'h02, 3'h4, 1'h1},
    '{2'h2, 2'h2, 1'h0, 8'h03, 8'h02, 4'h2, 8'h00, 3'h2, 1'h0},
    '{2'h2, 2'h3, 1'h0, 8'h01, 8'h00, 4'h2, 8'h00, 3'h6, 1'h1}
  };
  logic       clk_sys_i;
  logic       sys_rst_i;
  logic       clk_en_i;
  logic       timer_tick_i;
  logic       ovf_serviced_i;
  logic       match_serviced_i;
  axi_req_t   req;
  axi_rsp_t   rsp;
  pin_t       pin;
  logic [7:0] cnt;
  logic       ovf_flag;
  logic       match_flag;
  logic       pad;
  int         errors;
  int         checks;

  always #25 clk_sys_i = ~clk_sys_i;

  timer8_compare_unit timer8_compare_unit_i (
    .clk_sys_i        (clk_sys_i),
    .sys_rst_i        (sys_rst_i),
    .clk_en_i         (clk_en_i),
    .timer_tick_i     (timer_tick_i),
    .ovf_serviced_i   (ovf_serviced_i),
    .match_serviced_i (match_serviced_i),
    .axi_req_i        (req),
    .axi_rsp_o        (rsp),
    .pin_o            (pin),
    .counter_value_o  (cnt),
    .overflow_flag_o  (ovf_flag),
    .match_flag_o     (match_flag)
  );

  pin_pad_model pin_pad_model_i (
    .pin_i (pin),
    .pad_o (pad)
  );

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic hang();
    errors++;
    $display("unexpected at %0t: bus answer never came", $time);
    stop_test();
  endtask

  // sampling at the falling edge keeps the handshake free of edge races
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, bt;
    logic [1:0] rp;
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(negedge clk_sys_i);
      ta = req.awvalid & rsp.awready;
      tw = req.wvalid & rsp.wready;
      bt = rsp.bvalid;
      rp = rsp.bresp;
      @(posedge clk_sys_i);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      if (bt) begin
        req.bready <= 1'b0;
        chk({30'h0, rp}, {30'h0, er}, "bresp");
        // let an edge pass so the next call never reassigns bready in this step
        @(posedge clk_sys_i);
        return;
      end
    end
    hang();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, rt;
    logic [31:0] dv;
    logic [1:0] rp;
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(negedge clk_sys_i);
      ta = req.arvalid & rsp.arready;
      rt = rsp.rvalid;
      dv = rsp.rdata;
      rp = rsp.rresp;
      @(posedge clk_sys_i);
      if (ta) req.arvalid <= 1'b0;
      if (rt) begin
        req.rready <= 1'b0;
        chk(dv, ed, "rdata");
        chk({30'h0, rp}, {30'h0, er}, "rresp");
        @(posedge clk_sys_i);
        return;
      end
    end
    hang();
  endtask

  // one-cycle tick pulses with an idle cycle between, as a prescaler would give
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      timer_tick_i <= 1'b1;
      @(posedge clk_sys_i);
      timer_tick_i <= 1'b0;
    end
    // one quiet edge, so the counter port is settled when the caller reads it
    @(posedge clk_sys_i);
  endtask

  task automatic serv(input logic [1:0] s);
    {ovf_serviced_i, match_serviced_i} <= s;
    @(posedge clk_sys_i);
    {ovf_serviced_i, match_serviced_i} <= 2'h0;
  endtask

  task automatic pin_chk(input logic ep, input logic eoe);
    @(negedge clk_sys_i);
    chk({31'h0, pad}, {31'h0, ep}, "pad level");
    chk({31'h0, pin.oe}, {31'h0, eoe}, "pin enable");
    @(posedge clk_sys_i);
  endtask

  initial begin
    clk_sys_i = 1'b0;
    sys_rst_i = 1'b1;
    clk_en_i = 1'b1;
    timer_tick_i = 1'b0;
    ovf_serviced_i = 1'b0;
    match_serviced_i = 1'b0;
    req = '0;
    errors = 0;
    checks = 0;
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rd(COUNT_OFS, 32'h0, RESP_OKAY);
    rd(FLAGS_OFS, 32'h0, RESP_OKAY);
    pin_chk(1'b1, 1'b0);
    $display("test reset done");
    foreach (ROWS[i]) begin
      wr(CTRL_OFS, {22'h0, ROWS[i].pt, 1'b1, 2'h0, ROWS[i].ac, 2'h0, ROWS[i].md}, RESP_OKAY);
      wr(MATCH_OFS, {24'h0, ROWS[i].mv}, RESP_OKAY);
      wr(FLAGS_OFS, 32'h3, RESP_OKAY);
      wr(COUNT_OFS, {24'h0, ROWS[i].cv}, RESP_OKAY);
      ticks(ROWS[i].n);
      chk({24'h0, cnt}, {24'h0, ROWS[i].ec}, "counter port");
      chk({31'h0, ovf_flag}, {31'h0, ROWS[i].ef[0]}, "overflow port");
      chk({31'h0, match_flag}, {31'h0, ROWS[i].ef[1]}, "match port");
      rd(COUNT_OFS, {24'h0, ROWS[i].ec}, RESP_OKAY);
      rd(FLAGS_OFS, {29'h0, ROWS[i].ef}, RESP_OKAY);
      pin_chk(ROWS[i].ep, 1'b1);
      $display("row %0d done", i);
    end
    // force with the pin released sets up a known level before enabling it
    wr(FLAGS_OFS, 32'h3, RESP_OKAY);
    wr(COUNT_OFS, 32'h40, RESP_OKAY);
    wr(CTRL_OFS, 32'ha0, RESP_OKAY);
    rd(FLAGS_OFS, 32'h0, RESP_OKAY);
    rd(COUNT_OFS, 32'h40, RESP_OKAY);
    pin_chk(1'b1, 1'b0);
    wr(CTRL_OFS, 32'h120, RESP_OKAY);
    pin_chk(1'b0, 1'b1);
    wr(CTRL_OFS, 32'hb2, RESP_OKAY);
    // pwm mode set first, so the later strobe meets a pwm mode already in place
    wr(CTRL_OFS, 32'h23, RESP_OKAY);
    wr(CTRL_OFS, 32'ha3, RESP_OKAY);
    rd(FLAGS_OFS, 32'h4, RESP_OKAY);
    rd(CTRL_OFS, 32'h23, RESP_OKAY);
    $display("test force done");
    wr(8'h10, 32'h1, RESP_SLVERR);
    rd(8'h10, 32'h0, RESP_SLVERR);
    $display("test unmapped done");
    wr(CTRL_OFS, 32'h0, RESP_OKAY);
    wr(MATCH_OFS, 32'h0, RESP_OKAY);
    wr(COUNT_OFS, 32'hff, RESP_OKAY);
    ticks(2);
    rd(FLAGS_OFS, 32'h7, RESP_OKAY);
    wr(FLAGS_OFS, 32'h0, RESP_OKAY);
    rd(FLAGS_OFS, 32'h7, RESP_OKAY);
    serv(2'h2);
    rd(FLAGS_OFS, 32'h6, RESP_OKAY);
    serv(2'h1);
    rd(FLAGS_OFS, 32'h4, RESP_OKAY);
    $display("test flags done");
    // clock enable low: ticks must not move the counter
    clk_en_i <= 1'b0;
    ticks(2);
    chk({24'h0, cnt}, 32'h1, "frozen counter");
    clk_en_i <= 1'b1;
    $display("test freeze done");
    stop_test();
  end
endmodule
